//--- dv/scs_switcher_properties.sv
// Purpose: Port checks for the clock switcher
// Assumes: Fuses held steady between resets
// Notes: Gated two edges after reset so fuse loading is not flagged
`timescale 1ns/1ps
`include "scs_defs.vh"
module scs_switcher_properties (
    input wire sys_clk_in,
    input wire resetn_in,
    input wire [3:0] addr_in,
    input wire wr_in,
    input wire rd_in,
    input wire [15:0] rdata_out,
    input wire switch_monitor_fuse_in,
    input wire [2:0] sys_clk_sel_out,
    input wire [3:0] osc_enable_out,
    input wire pll_enable_out,
    input wire [5:0] trim_code_field_out,
    input wire switching_out
);
    reg [1:0] up;
    wire live;
    assign live = up[1];
    function [1:0] osc_of(input [2:0] s);
        case (s)
            `SCS_SRC_PRI, `SCS_SRC_PRI_PLL: osc_of = 2'd0;
            `SCS_SRC_LP: osc_of = 2'd1;
            `SCS_SRC_SLOW_INTERNAL_OSC: osc_of = 2'd3;
            default: osc_of = 2'd2;
        endcase
    endfunction
    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in)
            up <= 2'b00;
        else
            up <= {up[0], 1'b1};
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);
    a_sel_legal: assert property (live |-> sys_clk_sel_out <= 3'h5)
        else $error("selected source code out of range");
    a_fuse_blocks: assert property (live && switch_monitor_fuse_in |-> !switching_out)
        else $error("sequencing while switching is locked");
    a_fuse_sel: assert property (live && switch_monitor_fuse_in |-> $stable(sys_clk_sel_out))
        else $error("source moved while switching is locked");
    a_req_zero: assert property (live && switch_monitor_fuse_in && $past(rd_in)
        && $past(addr_in) == 4'h0 |-> !rdata_out[0]) else $error("request bit read as one");
    a_sel_switch: assert property (live && !$past(switching_out) |-> $stable(sys_clk_sel_out))
        else $error("source changed outside a switch");
    a_target_on: assert property (live && !switching_out
        |-> osc_enable_out[osc_of(sys_clk_sel_out)]) else $error("selected oscillator off");
    a_pll_held: assert property (live && !switching_out && (sys_clk_sel_out == 3'h1
        || sys_clk_sel_out == 3'h3) |-> pll_enable_out) else $error("PLL source without PLL");
    a_trim_write: assert property (live && !($past(wr_in) && $past(addr_in) == 4'h1)
        |-> $stable(trim_code_field_out)) else $error("trim changed without a write");
endmodule // scs_switcher_properties
bind scs_switcher scs_switcher_properties i_scs_switcher_properties (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .addr_in(addr_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .switch_monitor_fuse_in(switch_monitor_fuse_in),
    .sys_clk_sel_out(sys_clk_sel_out), .osc_enable_out(osc_enable_out),
    .pll_enable_out(pll_enable_out), .trim_code_field_out(trim_code_field_out),
    .switching_out(switching_out));

//--- dv/scs_switcher_test.sv
// Purpose: Register-level tests of the clock switcher
// Assumes: All oscillators report ready, bar the slow one early in the last switch; ticks stand for the new clock
// Notes: Ticks are slow so the synchroniser sees every edge
`timescale 1ns/1ps
`include "scs_defs.vh"
module scs_switcher_test;
    reg sys_clk_in = 1'b0;
    reg resetn_in = 1'b0;
    reg [3:0] addr_in = 4'h0;
    reg [15:0] wdata_in = 16'h0000;
    reg wr_in = 1'b0;
    reg rd_in = 1'b0;
    reg fuse = 1'b1;
    reg [2:0] init_src = 3'h2;
    reg wdog = 1'b0;
    reg lock = 1'b0;
    reg tick = 1'b0;
    reg fail = 1'b0;
    reg [3:0] rdy = 4'hf;
    wire pll;
    reg [15:0] got;
    wire [15:0] rdata_out;
    wire [2:0] sel;
    wire [3:0] en;
    wire [5:0] trim;
    wire busy;
    integer mismatches = 0;
    integer n_tests = 0;
    integer cycles = 0;
    always #5 sys_clk_in = ~sys_clk_in;
    scs_switcher i_scs_switcher (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .switch_monitor_fuse_in(fuse), .initial_source_fuse_in(init_src),
        .watchdog_en_in(wdog), .osc_ready_in(rdy), .pll_lock_in(lock), .new_clk_tick_in(tick),
        .clock_fail_in(fail), .sys_clk_sel_out(sel), .osc_enable_out(en), .pll_enable_out(pll),
        .trim_code_field_out(trim), .switching_out(busy));
    task complete_run;
        begin
            if (mismatches == 0 && n_tests > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    task chk(input [15:0] seen, input [15:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [3:0] a, input [15:0] d);
        begin
            @(posedge sys_clk_in);
            addr_in <= a;
            wdata_in <= d;
            wr_in <= 1'b1;
            @(posedge sys_clk_in);
            wr_in <= 1'b0;
        end
    endtask
    task rd(input [3:0] a);
        begin
            @(posedge sys_clk_in);
            addr_in <= a;
            rd_in <= 1'b1;
            @(posedge sys_clk_in);
            rd_in <= 1'b0;
            #1 got = rdata_out;
        end
    endtask
    // Keys must land on adjacent cycles, so the strobe stays up between them
    task unlock;
        begin
            @(posedge sys_clk_in);
            addr_in <= `SCS_OSC_CONTROL_REG;
            wdata_in <= {8'h00, `SCS_KEY1};
            wr_in <= 1'b1;
            @(posedge sys_clk_in);
            wdata_in <= {8'h00, `SCS_KEY2};
            @(posedge sys_clk_in);
            wr_in <= 1'b0;
        end
    endtask
    task request(input [2:0] src);
        begin
            unlock;
            wr(`SCS_OSC_CONTROL_REG, {5'h00, src, 8'h00});
            unlock;
            wr(`SCS_OSC_CONTROL_REG, 16'h0001);
        end
    endtask
    task ticks(input integer n);
        begin
            repeat (n) begin
                @(posedge sys_clk_in);
                tick <= 1'b1;
                repeat (3) @(posedge sys_clk_in);
                tick <= 1'b0;
                repeat (3) @(posedge sys_clk_in);
            end
        end
    endtask
    task do_reset(input f, input [2:0] s);
        begin
            resetn_in <= 1'b0;
            fuse <= f;
            init_src <= s;
            repeat (2) @(posedge sys_clk_in);
            resetn_in <= 1'b1;
            repeat (2) @(posedge sys_clk_in);
        end
    endtask
    // Ceiling is several times the expected run
    always @(posedge sys_clk_in) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            mismatches = mismatches + 1;
            complete_run;
        end
    end
    initial begin
        do_reset(1'b1, `SCS_SRC_PRI);
        rd(`SCS_FAST_OSC_TRIM);
        chk(got, 16'h0000);
        wr(`SCS_FAST_OSC_TRIM, 16'hffdf);
        rd(`SCS_FAST_OSC_TRIM);
        chk(got, 16'h001f);
        chk({10'h000, trim}, 16'h001f);
        request(`SCS_SRC_SLOW_INTERNAL_OSC);
        ticks(12);
        rd(`SCS_OSC_CONTROL_REG);
        chk(got & 16'h7001, 16'h2000);
        chk({13'h0000, sel}, {13'h0000, `SCS_SRC_PRI});
        do_reset(1'b0, `SCS_SRC_FRC);
        wr(`SCS_OSC_CONTROL_REG, 16'h0400);
        rd(`SCS_OSC_CONTROL_REG);
        chk(got & 16'h0700, 16'h0000);
        fail <= 1'b1;
        repeat (4) @(posedge sys_clk_in);
        fail <= 1'b0;
        unlock;
        wr(`SCS_OSC_CONTROL_REG, 16'h0001);
        repeat (4) @(posedge sys_clk_in);
        rd(`SCS_OSC_CONTROL_REG);
        chk(got & 16'h7009, 16'h0008);
        chk({15'h0000, busy}, 16'h0000);
        request(`SCS_SRC_PRI_PLL);
        rd(`SCS_OSC_CONTROL_REG);
        chk(got & 16'h0028, 16'h0000);
        ticks(12);
        chk({13'h0000, sel}, 16'h0000);
        lock <= 1'b1;
        repeat (4) @(posedge sys_clk_in);
        ticks(9);
        repeat (4) @(posedge sys_clk_in);
        chk({13'h0000, sel}, 16'h0000);
        rd(`SCS_OSC_CONTROL_REG);
        chk(got & 16'h0301, 16'h0301);
        ticks(1);
        repeat (6) @(posedge sys_clk_in);
        chk({13'h0000, sel}, {13'h0000, `SCS_SRC_PRI_PLL});
        rd(`SCS_OSC_CONTROL_REG);
        chk(got & 16'h7721, 16'h3320);
        chk({12'h000, en & 4'h5}, 16'h0001);
        chk({15'h0000, pll}, 16'h0001);
        wdog <= 1'b1;
        rdy <= 4'h7;
        request(`SCS_SRC_SLOW_INTERNAL_OSC);
        ticks(10);
        chk({13'h0000, sel}, {13'h0000, `SCS_SRC_PRI_PLL});
        chk({12'h000, en & 4'h8}, 16'h0008);
        chk({15'h0000, busy}, 16'h0001);
        rdy <= 4'hf;
        ticks(10);
        repeat (6) @(posedge sys_clk_in);
        chk({13'h0000, sel}, {13'h0000, `SCS_SRC_SLOW_INTERNAL_OSC});
        chk({12'h000, en & 4'h9}, 16'h0008);
        chk({15'h0000, pll}, 16'h0000);
        complete_run;
    end
endmodule // scs_switcher_test

//--- hw/scs_defs.vh
// Purpose: Constants for the system clock switcher
// Assumes: 16-bit register port, word index addresses
// Notes: Source codes follow the 3-bit next/current source encoding
// How it works
// - Six-bit trim code tunes fast oscillator
// - Software may select any clock source
// - Primary submode fixed by fuses only
// - Switching enabled only when fuse is zero
// - Disabled: next field ignored, status shows fuse
// - Disabled: request bit ignored, reads zero
// - Same source requested: clear request, abort
// - Valid switch clears lock and fail flags
// - Start target oscillator, await crystal start-up
// - PLL target: wait for lock
// - Count ten new-clock cycles, then change over
// - Clear request, copy next into current
// - Stop old source, keep slow/low-power if needed
// - Processor keeps running during the switch
`ifndef SCS_DEFS_VH
`define SCS_DEFS_VH
`define SCS_ADDR_W 4
`define SCS_OSC_CONTROL_REG 4'h0
`define SCS_FAST_OSC_TRIM 4'h1
`define SCS_TRIM_RESET 6'h00
`define SCS_SRC_FRC 3'h0
`define SCS_SRC_FRC_PLL 3'h1
`define SCS_SRC_PRI 3'h2
`define SCS_SRC_PRI_PLL 3'h3
`define SCS_SRC_LP 3'h4
`define SCS_SRC_SLOW_INTERNAL_OSC 3'h5
`define SCS_KEY1 8'h5a
`define SCS_KEY2 8'ha5
`define SCS_KEY_WIN 4'h4
`define SCS_SETTLE_CYCLES 4'ha
`define SCS_CUR_LSB 12
`define SCS_NEXT_LSB 8
`define SCS_LOCK_BIT 5
`define SCS_FAIL_BIT 3
`define SCS_LPKEEP_BIT 1
`define SCS_REQ_BIT 0
`endif

//--- hw/scs_settle.v
// Purpose: Counts cycles of the incoming clock before changeover
// Assumes: Ticks already synchronised into the system domain
// Notes: Reports done until cleared by start
`timescale 1ns/1ps
`include "scs_defs.vh"
module scs_settle (
    input wire sys_clk_in,
    input wire resetn_in,
    input wire start_in,
    input wire tick_in,
    output reg done_out
);
    reg [3:0] cnt;
    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt <= 4'h0;
            done_out <= 1'b0;
        end else if (start_in) begin
            cnt <= 4'h0;
            done_out <= 1'b0;
        end else if (tick_in && !done_out) begin
            if (cnt == `SCS_SETTLE_CYCLES - 4'h1)
                done_out <= 1'b1;
            cnt <= cnt + 4'h1;
        end
    end
endmodule // scs_settle

//--- hw/scs_switcher.v
// Purpose: Clock source selection and run-time switching sequencer
// Assumes: Oscillator ready, lock and new-clock ticks are async pins
// Notes: Processor runs throughout; block never stalls the bus
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "scs_defs.vh"
module scs_switcher (
    input wire sys_clk_in,
    input wire resetn_in,
    input wire [3:0] addr_in,
    input wire [15:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [15:0] rdata_out,
    input wire switch_monitor_fuse_in,
    input wire [2:0] initial_source_fuse_in,
    input wire watchdog_en_in,
    input wire [3:0] osc_ready_in,
    input wire pll_lock_in,
    input wire new_clk_tick_in,
    input wire clock_fail_in,
    output reg [2:0] sys_clk_sel_out,
    output reg [3:0] osc_enable_out,
    output reg pll_enable_out,
    output reg [5:0] trim_code_field_out,
    output wire switching_out
);
    // Oscillator enable bits: 0 primary, 1 low-power, 2 fast, 3 slow
    localparam ST_IDLE = 4'b0001;
    localparam ST_WAIT = 4'b0010;
    localparam ST_SETTLE = 4'b0100;
    localparam ST_DONE = 4'b1000;

    function [3:0] osc_of;
        input [2:0] src;
        begin
            case (src)
                `SCS_SRC_PRI, `SCS_SRC_PRI_PLL: osc_of = 4'h1;
                `SCS_SRC_LP: osc_of = 4'h2;
                `SCS_SRC_SLOW_INTERNAL_OSC: osc_of = 4'h8;
                default: osc_of = 4'h4;
            endcase
        end
    endfunction

    function uses_pll;
        input [2:0] src;
        begin
            uses_pll = (src == `SCS_SRC_FRC_PLL) || (src == `SCS_SRC_PRI_PLL);
        end
    endfunction

    reg [3:0] state;
    reg [3:0] next_state;
    reg [2:0] current_source_status;
    reg [2:0] next_source_sel;
    reg switch_request;
    reg lock_flag;
    reg clock_fail_flag;
    reg low_power_osc_keep;
    reg fuse_loaded;
    reg sw_en;
    reg [3:0] rdy_s1, rdy_s2;
    reg lock_s1, lock_s2;
    reg tick_s1, tick_s2, tick_s3;
    reg fail_s1, fail_s2;
    wire tick_edge;
    wire settled;
    wire unlocked;
    wire ctl_sel;
    wire hi_wr;
    wire lo_wr;
    wire key_wr;
    wire target_ready;
    wire fail_evt;

    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdy_s1 <= 4'h0;
            rdy_s2 <= 4'h0;
            lock_s1 <= 1'b0;
            lock_s2 <= 1'b0;
            tick_s1 <= 1'b0;
            tick_s2 <= 1'b0;
            tick_s3 <= 1'b0;
            fail_s1 <= 1'b0;
            fail_s2 <= 1'b0;
        end else begin
            rdy_s1 <= osc_ready_in;
            rdy_s2 <= rdy_s1;
            lock_s1 <= pll_lock_in;
            lock_s2 <= lock_s1;
            tick_s1 <= new_clk_tick_in;
            tick_s2 <= tick_s1;
            tick_s3 <= tick_s2;
            fail_s1 <= clock_fail_in;
            fail_s2 <= fail_s1;
        end
    end
    assign tick_edge = tick_s2 & ~tick_s3;
    assign fail_evt = fail_s2;

    // Keys written to the low byte with the high byte zero
    assign ctl_sel = wr_in && (addr_in == `SCS_OSC_CONTROL_REG);
    assign key_wr = ctl_sel && (wdata_in[15:8] == 8'h00) &&
        ((wdata_in[7:0] == `SCS_KEY1) || (wdata_in[7:0] == `SCS_KEY2));
    assign hi_wr = ctl_sel && !key_wr && unlocked && (wdata_in[7:0] == 8'h00);
    assign lo_wr = ctl_sel && !key_wr && unlocked && (wdata_in[15:8] == 8'h00);

    scs_unlock u_unlock (
        .sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in),
        .key_wr_in(key_wr),
        .key_in(wdata_in[7:0]),
        .consume_in(hi_wr | lo_wr),
        .unlocked_out(unlocked)
    );

    assign target_ready = ((rdy_s2 & osc_of(next_source_sel)) != 4'h0) &&
        (!uses_pll(next_source_sel) || lock_s2);

    scs_settle u_settle (
        .sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in),
        .start_in(state != ST_SETTLE),
        .tick_in(tick_edge),
        .done_out(settled)
    );

    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (switch_request && sw_en && current_source_status != next_source_sel)
                    next_state = ST_WAIT;
            end
            ST_WAIT: begin
                if (target_ready)
                    next_state = ST_SETTLE;
            end
            ST_SETTLE: begin
                if (settled)
                    next_state = ST_DONE;
            end
            ST_DONE: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state <= ST_IDLE;
            fuse_loaded <= 1'b0;
            sw_en <= 1'b0;
            current_source_status <= `SCS_SRC_FRC;
            next_source_sel <= `SCS_SRC_FRC;
            switch_request <= 1'b0;
            lock_flag <= 1'b0;
            clock_fail_flag <= 1'b0;
            low_power_osc_keep <= 1'b0;
            trim_code_field_out <= `SCS_TRIM_RESET;
            sys_clk_sel_out <= `SCS_SRC_FRC;
            osc_enable_out <= 4'h4;
            pll_enable_out <= 1'b0;
        end else begin
            state <= next_state;
            if (!fuse_loaded) begin
                // Fuses are caught once after reset release
                fuse_loaded <= 1'b1;
                sw_en <= !switch_monitor_fuse_in;
                current_source_status <= initial_source_fuse_in;
                next_source_sel <= initial_source_fuse_in;
                sys_clk_sel_out <= initial_source_fuse_in;
                osc_enable_out <= osc_of(initial_source_fuse_in);
                pll_enable_out <= uses_pll(initial_source_fuse_in);
            end
            if (wr_in && addr_in == `SCS_FAST_OSC_TRIM)
                trim_code_field_out <= wdata_in[5:0];
            // Primary submode stays on fuse pins; only the source code moves
            if (hi_wr && sw_en && state == ST_IDLE)
                next_source_sel <= wdata_in[`SCS_NEXT_LSB +: 3];
            if (lo_wr) begin
                low_power_osc_keep <= wdata_in[`SCS_LPKEEP_BIT];
                if (sw_en && wdata_in[`SCS_REQ_BIT])
                    switch_request <= 1'b1;
            end
            if (!sw_en)
                switch_request <= 1'b0;
            if (state == ST_IDLE && switch_request && sw_en) begin
                if (current_source_status == next_source_sel) begin
                    switch_request <= 1'b0;
                end else begin
                    lock_flag <= 1'b0;
                    clock_fail_flag <= 1'b0;
                    osc_enable_out <= osc_enable_out | osc_of(next_source_sel);
                    pll_enable_out <= pll_enable_out | uses_pll(next_source_sel);
                end
            end
            // An event on the start cycle outranks the clear so it is never lost
            if (lock_s2 && pll_enable_out)
                lock_flag <= 1'b1;
            if (fail_evt && sw_en)
                clock_fail_flag <= 1'b1;
            if (state == ST_SETTLE && settled) begin
                sys_clk_sel_out <= next_source_sel;
                current_source_status <= next_source_sel;
                switch_request <= 1'b0;
            end
            if (state == ST_DONE) begin
                // Old source off, keepers retained
                osc_enable_out <= osc_of(current_source_status) |
                    ((watchdog_en_in || sw_en) ? 4'h8 : 4'h0) |
                    (low_power_osc_keep ? 4'h2 : 4'h0);
                pll_enable_out <= uses_pll(current_source_status);
            end
        end
    end

    // Status only; the bus is never held off while switching
    assign switching_out = (state != ST_IDLE);

    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_out <= 16'h0000;
        end else if (rd_in) begin
            case (addr_in)
                `SCS_OSC_CONTROL_REG: rdata_out <= {1'b0, current_source_status, 1'b0,
                    next_source_sel, 2'b00, lock_flag, 1'b0, clock_fail_flag, 1'b0,
                    low_power_osc_keep, switch_request & sw_en};
                `SCS_FAST_OSC_TRIM: rdata_out <= {10'h000, trim_code_field_out};
                default: rdata_out <= 16'h0000;
            endcase
        end else begin
            rdata_out <= 16'h0000;
        end
    end
endmodule // scs_switcher

//--- hw/scs_unlock.v
// Purpose: Unlock key detector for protected byte writes
// Assumes: Keys arrive as writes to the control register low byte
// Notes: Grants one write within a short window
`timescale 1ns/1ps
`include "scs_defs.vh"
module scs_unlock (
    input wire sys_clk_in,
    input wire resetn_in,
    input wire key_wr_in,
    input wire [7:0] key_in,
    input wire consume_in,
    output wire unlocked_out
);
    reg got_first;
    reg [3:0] win;
    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            got_first <= 1'b0;
            win <= 4'h0;
        end else if (key_wr_in && key_in == `SCS_KEY1) begin
            got_first <= 1'b1;
            win <= 4'h0;
        end else if (key_wr_in && got_first && key_in == `SCS_KEY2) begin
            got_first <= 1'b0;
            win <= `SCS_KEY_WIN;
        end else begin
            got_first <= 1'b0;
            if (consume_in)
                win <= 4'h0;
            else if (win != 4'h0)
                win <= win - 4'h1;
        end
    end
    assign unlocked_out = (win != 4'h0);
endmodule // scs_unlock
